// >>> verilog/order_code_pkg.sv
// order word layout, operation codes, control states and carriers
package order_code_pkg;

    // word and field widths
    localparam int WORD_W      = 16;
    localparam int ADDR_W      = 11;
    localparam int OP_W        = 5;
    localparam int SHIFT_W     = 4;
    localparam int STORE_DEPTH = 2048;
    localparam int SIGN_BIT    = 15;
    localparam int MAG_W       = 15;
    localparam int KEEP_LSB    = 11;

    // reset values
    localparam logic [ADDR_W-1:0] PC_RESET   = 11'h000;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

    typedef logic [WORD_W-1:0] word_t;
    typedef logic [ADDR_W-1:0] reg_num_t;

    // operation codes
    typedef enum logic [OP_W-1:0] {
        clear_then_add    = 5'h00,
        clear_then_sub    = 5'h01,
        add_op            = 5'h02,
        sub_op            = 5'h03,
        mul_round_op      = 5'h04,
        mul_hold_op       = 5'h05,
        divide_op         = 5'h06,
        store_op          = 5'h07,
        shift_right_op    = 5'h08,
        shift_left_op     = 5'h09,
        subprogram_jump   = 5'h0a,
        conditional_jump  = 5'h0b,
        digit_transfer_op = 5'h0c,
        test_out_op       = 5'h0d,
        multi_add_op      = 5'h0e
    } opcode_t;

    // order word: operation code on top, register number below
    typedef struct packed {
        opcode_t  op;
        reg_num_t reg_num;
    } order_t;

    // test output strobe with its word
    typedef struct packed {
        logic  valid;
        word_t data;
    } test_out_t;

    // storage load request from the outside while stopped
    typedef struct packed {
        logic     en;
        reg_num_t addr;
        word_t    data;
    } load_req_t;

    // control sequencer states, one-hot
    typedef enum logic [4:0] {
        st_idle  = 5'h01,
        st_fetch = 5'h02,
        st_order = 5'h04,
        st_oper  = 5'h08,
        st_exec  = 5'h10
    } ctl_state_t;

    // who drives the main bus
    typedef enum logic [1:0] {
        bus_storage = 2'h0,
        bus_accum   = 2'h1,
        bus_merge   = 2'h2,
        bus_load    = 2'h3
    } bus_src_t;

endpackage

// >>> verilog/storage_array.sv
// storage registers shared by orders and numbers, registered read
`timescale 1ns/1ps
module storage_array #(
    parameter int DEPTH = 2048,
    parameter int AW    = 11,
    parameter int DW    = 16
) (
    input  wire logic          i_clk_sys,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic          i_we,
    input  wire logic [DW-1:0] i_wdata,
    output logic      [DW-1:0] o_rdata
);

    // every location alike, no kind of word tied to any address
    logic [DW-1:0] mem_q [DEPTH];

    // write port
    always_ff @(posedge i_clk_sys) begin
        if (i_we) begin
            mem_q[i_addr] <= i_wdata;
        end
    end

    // read port, data one cycle after the address
    always_ff @(posedge i_clk_sys) begin
        o_rdata <= mem_q[i_addr];
    end

endmodule

// >>> verilog/arith_element.sv
// ones-complement arithmetic element, combinational
`timescale 1ns/1ps
module arith_element
    import order_code_pkg::*;
(
    input  wire opcode_t           i_op,
    input  wire word_t             i_acc,
    input  wire word_t             i_low,
    input  wire word_t             i_operand,
    input  wire logic              i_carry,
    input  wire logic [SHIFT_W-1:0] i_shift,
    output word_t                  o_acc,
    output word_t                  o_low,
    output logic                   o_carry
);

    // add with end-around carry
    function automatic word_t oc_add(input word_t a, input word_t b);
        logic [WORD_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[WORD_W-1:0] + {{(WORD_W-1){1'b0}}, s[WORD_W]};
    endfunction

    // magnitude of a ones-complement word
    function automatic logic [MAG_W-1:0] mag(input word_t w);
        return w[SIGN_BIT] ? ~w[MAG_W-1:0] : w[MAG_W-1:0];
    endfunction

    // sign and magnitude back to ones-complement
    function automatic word_t signed_word(input logic neg,
                                          input logic [MAG_W-1:0] m);
        return neg ? ~{1'b0, m} : {1'b0, m};
    endfunction

    logic              neg_prod;  // sign of product or quotient
    logic [2*MAG_W-1:0] prod;     // full magnitude product
    logic [2*MAG_W-1:0] quot;     // magnitude quotient
    logic [MAG_W-1:0]   rounded;  // upper half rounded
    logic [2*WORD_W-1:0] pair;    // accumulator with low half
    logic [WORD_W:0]    chain;    // multiple-length sum with carry

    assign neg_prod = i_acc[SIGN_BIT] ^ i_operand[SIGN_BIT];
    assign prod     = mag(i_acc) * mag(i_operand);
    assign quot     = (mag(i_operand) == '0) ? '1 :
                      {mag(i_acc), {MAG_W{1'b0}}} /
                      {{MAG_W{1'b0}}, mag(i_operand)};
    assign rounded  = prod[2*MAG_W-1:MAG_W] +
                      {{(MAG_W-1){1'b0}}, prod[MAG_W-1]};
    assign pair     = {i_acc, i_low};
    assign chain    = {1'b0, i_acc} + {1'b0, i_operand} +
                      {{WORD_W{1'b0}}, i_carry};

    // operation select
    always_comb begin
        o_acc   = i_acc;
        o_low   = i_low;
        o_carry = i_carry;
        case (i_op)
            clear_then_add: o_acc = i_operand;
            clear_then_sub: o_acc = ~i_operand;
            add_op:         o_acc = oc_add(i_acc, i_operand);
            sub_op:         o_acc = oc_add(i_acc, ~i_operand);
            mul_round_op: begin
                o_acc = signed_word(neg_prod, rounded);
                o_low = WORD_RESET;
            end
            mul_hold_op: begin
                o_acc = signed_word(neg_prod, prod[2*MAG_W-1:MAG_W]);
                o_low = signed_word(neg_prod, prod[MAG_W-1:0]);
            end
            divide_op: o_low = signed_word(neg_prod, quot[MAG_W-1:0]);
            shift_right_op: begin
                {o_acc, o_low} = $signed(pair) >>> i_shift;
            end
            shift_left_op: begin
                {o_acc, o_low} = pair << i_shift;
            end
            multi_add_op: begin
                o_acc   = chain[WORD_W-1:0];
                o_carry = chain[WORD_W];
            end
            default: begin
                o_acc   = i_acc;
                o_low   = i_low;
                o_carry = i_carry;
            end
        endcase
    end

endmodule

// >>> verilog/order_code_decoder.sv
// order fetch, decode and sequencing around one shared main bus
//
// How it works
// RULE_01: orders are plain binary words
// RULE_02: orders and numbers share one storage
// RULE_03: any register holds order or number
// RULE_04: one selection switch, one main bus
// RULE_05: fetched bus word is executed as order
// RULE_06: order words may be altered arithmetically
// RULE_07: each transfer touches storage, one at a time
// RULE_08: order splits into register number, code
// RULE_09: register number is eleven bits
// RULE_10: operation code is five bits
// RULE_11: order and register length sixteen bits
// RULE_12: add, complement subtract, multiply codes
// RULE_13: divide and left/right shift codes
// RULE_14: subprogram order jumps to other sequence
// RULE_15: conditional jump only on negative sign
// RULE_16: digit transfer inserts register number field
// RULE_17: one test output order
// RULE_18: one multiple-length add order
// RULE_19: negation inverts every bit
// RULE_20: clear then add loads operand
// RULE_21: shifts use four register-number bits
// RULE_22: counter advances, loads on jumps
// RULE_23: code in top five bits
`timescale 1ns/1ps
module order_code_decoder
    import order_code_pkg::*;
(
    input  wire logic      i_clk_sys,
    input  wire logic      i_rst_n,
    input  wire logic      i_run,
    input  wire load_req_t i_load,
    output test_out_t      o_test_out,
    output reg_num_t       o_pc,
    output order_t         o_order,
    output logic           o_busy
);

    ////////////////////////////////////////////////////////////////////
    // declarations
    ////////////////////////////////////////////////////////////////////

    ctl_state_t state_q;          // sequencer state
    ctl_state_t state_d;          // next sequencer state
    reg_num_t   pc_q;             // next order address [RULE_09]
    order_t     order_q;          // order being executed [RULE_10]
    word_t      accumulator_reg;  // accumulator
    word_t      low_product_reg;  // low half of products and quotients
    logic       carry_q;          // carry kept for multiple-length add
    test_out_t  test_out_q;       // test output strobe

    word_t      main_bus;         // the single shared bus [RULE_11]
    word_t      storage_rd;       // storage read data
    reg_num_t   mem_addr;         // storage selection switch
    logic       mem_we;           // storage write strobe
    bus_src_t   bus_src;          // bus driver select

    word_t      ae_acc;           // arithmetic result, accumulator
    word_t      ae_low;           // arithmetic result, low half
    logic       ae_carry;         // arithmetic carry out

    ////////////////////////////////////////////////////////////////////
    // decode
    ////////////////////////////////////////////////////////////////////

    // state decode
    logic in_idle;
    logic in_fetch;
    logic in_order;
    logic in_oper;
    logic in_exec;
    assign in_idle  = (state_q == st_idle);
    assign in_fetch = (state_q == st_fetch);
    assign in_order = (state_q == st_order);
    assign in_oper  = (state_q == st_oper);
    assign in_exec  = (state_q == st_exec);

    // operation decode straight from the code field
    logic is_store;
    logic is_digit;
    logic is_test;
    logic is_jump;
    logic is_cond;
    logic is_arith;
    logic jump_taken;
    logic load_now;
    assign is_store = (order_q.op == store_op);
    assign is_digit = (order_q.op == digit_transfer_op);
    assign is_test  = (order_q.op == test_out_op);
    assign is_jump  = (order_q.op == subprogram_jump);
    assign is_cond  = (order_q.op == conditional_jump);
    // codes handled by the arithmetic element
    assign is_arith = (order_q.op == clear_then_add) ||
                      (order_q.op == clear_then_sub) ||
                      (order_q.op == add_op)         ||
                      (order_q.op == sub_op)         ||
                      (order_q.op == mul_round_op)   ||
                      (order_q.op == mul_hold_op)    ||
                      (order_q.op == divide_op)      ||
                      (order_q.op == shift_right_op) ||
                      (order_q.op == shift_left_op)  ||
                      (order_q.op == multi_add_op);    // [RULE_12] [RULE_13] [RULE_18]
    // sign bit set means negative
    assign jump_taken = is_jump ||
                        (is_cond && accumulator_reg[SIGN_BIT]); // [RULE_14] [RULE_15]
    // loading only while stopped
    assign load_now = in_idle && i_load.en;

    ////////////////////////////////////////////////////////////////////
    // storage switch and main bus
    ////////////////////////////////////////////////////////////////////

    // one switch picks the register: loader, counter or order field
    assign mem_addr = load_now ? i_load.addr :
                      in_fetch ? pc_q : order_q.reg_num; // [RULE_04] [RULE_08]

    // storage written from the bus only
    assign mem_we = load_now ||
                    (in_exec && (is_store || is_digit)); // [RULE_07]

    // bus driver select, one word at a time
    assign bus_src = load_now                ? bus_load  :
                     (in_exec && is_store)   ? bus_accum :
                     (in_exec && is_digit)   ? bus_merge :
                                               bus_storage; // [RULE_07]

    // bus mux; digit transfer keeps the code, takes the new number
    always_comb begin
        case (bus_src)
            bus_load:    main_bus = i_load.data;
            bus_accum:   main_bus = accumulator_reg;
            bus_merge:   main_bus = {storage_rd[WORD_W-1:KEEP_LSB],
                                     accumulator_reg[KEEP_LSB-1:0]}; // [RULE_16]
            bus_storage: main_bus = storage_rd;
            default:     main_bus = storage_rd;
        endcase
    end

    // any register, order or number, same storage
    storage_array #(
        .DEPTH (STORE_DEPTH),
        .AW    (ADDR_W),
        .DW    (WORD_W)
    ) u_storage (
        .i_clk_sys (i_clk_sys),
        .i_addr    (mem_addr),
        .i_we      (mem_we),
        .i_wdata   (main_bus),
        .o_rdata   (storage_rd)
    ); // [RULE_02] [RULE_03]

    ////////////////////////////////////////////////////////////////////
    // arithmetic element
    ////////////////////////////////////////////////////////////////////

    // operand is whatever word is on the bus, order words included
    arith_element u_arith (
        .i_op      (order_q.op),
        .i_acc     (accumulator_reg),
        .i_low     (low_product_reg),
        .i_operand (main_bus),
        .i_carry   (carry_q),
        .i_shift   (order_q.reg_num[SHIFT_W-1:0]),
        .o_acc     (ae_acc),
        .o_low     (ae_low),
        .o_carry   (ae_carry)
    ); // [RULE_06] [RULE_19] [RULE_21]

    // arithmetic registers update only on an executing arithmetic code
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            accumulator_reg <= WORD_RESET;
            low_product_reg <= WORD_RESET;
            carry_q         <= 1'b0;
        end else if (in_exec && is_arith) begin
            accumulator_reg <= ae_acc;   // [RULE_20]
            low_product_reg <= ae_low;
            carry_q         <= ae_carry; // [RULE_18]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer
    ////////////////////////////////////////////////////////////////////

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            st_idle: begin
                if (i_run && !i_load.en) begin
                    state_d = st_fetch;
                end
            end
            st_fetch: state_d = st_order;
            st_order: state_d = st_oper;
            st_oper:  state_d = st_exec;
            st_exec: begin
                state_d = i_run ? st_fetch : st_idle;
            end
            default: state_d = st_idle;
        endcase
    end

    // state register
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_q <= st_idle;
        end else begin
            state_q <= state_d;
        end
    end

    // order register: any fetched word is taken as an order
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            order_q <= order_t'(WORD_RESET);
        end else if (in_order) begin
            order_q <= order_t'(main_bus); // [RULE_01] [RULE_05] [RULE_23]
        end
    end

    // order counter: step after fetch, load on jumps
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            pc_q <= PC_RESET;
        end else if (in_order) begin
            pc_q <= pc_q + reg_num_t'(1);   // [RULE_22]
        end else if (in_exec && jump_taken) begin
            pc_q <= order_q.reg_num;        // [RULE_14] [RULE_15]
        end
    end

    // test output strobe, one cycle per order
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            test_out_q <= '0;
        end else begin
            test_out_q.valid <= in_exec && is_test; // [RULE_17]
            if (in_exec && is_test) begin
                test_out_q.data <= accumulator_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    ////////////////////////////////////////////////////////////////////

    assign o_test_out = test_out_q;
    assign o_pc       = pc_q;
    assign o_order    = order_q;
    assign o_busy     = !in_idle;

    ////////////////////////////////////////////////////////////////////
    // checks
    ////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    // one order walks fetch, order, operand, execute
    sequence s_order_walk;
        in_order ##1 in_oper ##1 in_exec;
    endsequence

    chk_order_walk_steps: assert property ( // [RULE_08]
        in_fetch |=> s_order_walk)
        else $error("order cycle did not walk its steps");

    chk_pc_steps_one: assert property ( // [RULE_22]
        in_order |=> pc_q == $past(pc_q) + reg_num_t'(1))
        else $error("order counter did not step by one");

    chk_jump_loads_pc: assert property ( // [RULE_14]
        in_exec && is_jump |=> pc_q == $past(order_q.reg_num))
        else $error("jump did not load the order counter");

    chk_cond_not_taken: assert property ( // [RULE_15]
        in_exec && is_cond && !accumulator_reg[SIGN_BIT]
        |=> pc_q == $past(pc_q))
        else $error("conditional jump taken on positive sign");

    chk_order_from_bus: assert property ( // [RULE_05]
        in_order |=> order_q == order_t'($past(main_bus)))
        else $error("order register missed the bus word");

    chk_store_word: assert property ( // [RULE_07]
        in_exec && is_store |-> mem_we &&
        main_bus == accumulator_reg && mem_addr == order_q.reg_num)
        else $error("store did not move the accumulator");

    chk_digit_merge: assert property ( // [RULE_16]
        in_exec && is_digit |-> mem_we &&
        main_bus[KEEP_LSB-1:0] == accumulator_reg[KEEP_LSB-1:0] &&
        main_bus[WORD_W-1:KEEP_LSB] == storage_rd[WORD_W-1:KEEP_LSB])
        else $error("digit transfer merged wrong fields");

    chk_test_strobe: assert property ( // [RULE_17]
        in_exec && is_test |=> o_test_out.valid &&
        o_test_out.data == $past(accumulator_reg) ##1 !o_test_out.valid)
        else $error("test output strobe wrong");

    chk_clear_add_load: assert property ( // [RULE_20]
        in_exec && order_q.op == clear_then_add
        |=> accumulator_reg == $past(storage_rd))
        else $error("clear then add did not load operand");

    chk_negate_invert: assert property ( // [RULE_19]
        in_exec && order_q.op == clear_then_sub
        |=> accumulator_reg == ~$past(storage_rd))
        else $error("negation is not a full inversion");

    chk_write_window: assert property ( // [RULE_04]
        mem_we |-> in_idle || in_exec)
        else $error("storage written outside its slots");

endmodule

// >>> verif/prog_loader.sv
// storage loader model: places orders and numbers through the load port
`timescale 1ns/1ps
module prog_loader
    import order_code_pkg::*;
(
    input  wire logic i_clk_sys,
    output load_req_t o_load
);
    // nothing requested at time zero
    initial begin
        o_load = '0;
    end

    ////////////////////////////////////////////////////////////////////
    // one word per edge; orders and numbers use the very same path,
    // to any address at all
    task automatic put(input reg_num_t addr, input word_t data);
        @(posedge i_clk_sys);
        o_load <= '{en: 1'b1, addr: addr, data: data};
    endtask

    // release: enable low, address and data inverted so nothing lingers
    task automatic stop();
        @(posedge i_clk_sys);
        o_load <= '{en: 1'b0, addr: ~o_load.addr, data: ~o_load.data};
    endtask
endmodule

// >>> verif/tb_order_code_decoder.sv
// self-checking bench for the order decoder, with a storage loader model
`timescale 1ns/1ps
module tb_order_code_decoder
    import order_code_pkg::*;
;
    logic      i_clk_sys;
    logic      i_rst_n;
    logic      i_run;
    load_req_t ld;
    test_out_t o_test_out;
    reg_num_t  o_pc;
    order_t    o_order;
    logic      o_busy;
    int        err_total;
    int        n_tests;
    word_t     outs[$];   // test output words seen in the current run

    // one case: second order, operands at 0x100/0x101, expected result
    typedef struct packed {
        word_t ord;
        word_t a;
        word_t b;
        word_t exp;
    } row_t;

    localparam int N_ROWS = 12;
    row_t rows [N_ROWS] = '{
        '{{add_op, 11'h101}, 16'h0003, 16'h0004, 16'h0007},
        '{{sub_op, 11'h101}, 16'h0007, 16'h0003, 16'h0004},
        '{{clear_then_sub, 11'h101}, 16'h1234, 16'h0005, 16'hfffa},
        '{{clear_then_add, 11'h101}, 16'h1234, 16'h00a5, 16'h00a5},
        '{{add_op, 11'h101}, 16'h0005, 16'hfffd, 16'h0003},
        '{{mul_round_op, 11'h101}, 16'h4000, 16'h4000, 16'h2000},
        '{{mul_hold_op, 11'h101}, 16'h4000, 16'h4000, 16'h2000},
        '{{shift_right_op, 11'h7f2}, 16'hfff0, 16'h0000, 16'hfffc},
        '{{shift_left_op, 11'h004}, 16'h0010, 16'h0000, 16'h0100},
        '{{multi_add_op, 11'h101}, 16'hffff, 16'h0002, 16'h0001},
        '{{5'h0f, 11'h101}, 16'h1234, 16'h0000, 16'h1234},
        '{{add_op, 11'h101}, 16'h6805, 16'h0001, 16'h6806}
    };

    // jump, sign test, digit transfer and store program
    word_t prog [13] = '{
        {clear_then_add, 11'h100}, {conditional_jump, 11'h004},
        {test_out_op, 11'h000}, {subprogram_jump, 11'h003},
        {clear_then_add, 11'h101}, {conditional_jump, 11'h003},
        {digit_transfer_op, 11'h008}, {store_op, 11'h103},
        {clear_then_add, 11'h7ff}, {test_out_op, 11'h000},
        {clear_then_add, 11'h103}, {test_out_op, 11'h000},
        {subprogram_jump, 11'h00c}
    };

    order_code_decoder dut_u (
        .i_clk_sys  (i_clk_sys),
        .i_rst_n    (i_rst_n),
        .i_run      (i_run),
        .i_load     (ld),
        .o_test_out (o_test_out),
        .o_pc       (o_pc),
        .o_order    (o_order),
        .o_busy     (o_busy)
    );

    prog_loader ldr (
        .i_clk_sys (i_clk_sys),
        .o_load    (ld)
    );

    ////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    // collect every test output pulse
    always @(posedge i_clk_sys) begin
        if (o_test_out.valid === 1'b1) begin
            outs.push_back(o_test_out.data);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // compare seen against expected, count both
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // hold reset for n edges, check cleared outputs, then release
    task automatic do_reset(input int n);
        @(posedge i_clk_sys);
        i_rst_n <= 1'b0;
        i_run   <= 1'b0;
        repeat (n) @(posedge i_clk_sys);
        #1;
        check("pc at reset", o_pc, 0);
        check("busy at reset", o_busy, 0);
        check("test out at reset", o_test_out, 0);
        check("order at reset", o_order, 0);
        @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
    endtask

    // run until npulse outputs, let it settle, stop, wait for idle
    task automatic go(input int npulse);
        int k;
        outs.delete();
        @(posedge i_clk_sys);
        i_run <= 1'b1;
        k = 0;
        while (outs.size() < npulse && k < 400) begin
            @(posedge i_clk_sys);
            k++;
        end
        repeat (24) @(posedge i_clk_sys);
        i_run <= 1'b0;
        k = 0;
        do begin
            @(posedge i_clk_sys);
            k++;
        end while (o_busy !== 1'b0 && k < 20);
        check("stopped", o_busy, 0);
        check("pulse count", outs.size(), npulse);
    endtask

    ////////////////////////////////////////////////////////////////////
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        err_total++;
        close_out();
    end

    // main sequence
    initial begin
        i_rst_n   = 1'b0;
        i_run     = 1'b0;
        err_total = 0;
        n_tests   = 0;
        do_reset(10);
        // table: one operation between a load and a test output
        for (int i = 0; i < N_ROWS; i++) begin
            do_reset(2);
            ldr.put(11'h000, {clear_then_add, 11'h100});
            ldr.put(11'h001, rows[i].ord);
            ldr.put(11'h002, {test_out_op, 11'h000});
            ldr.put(11'h003, {subprogram_jump, 11'h003});
            ldr.put(11'h100, rows[i].a);
            ldr.put(11'h101, rows[i].b);
            ldr.stop();
            go(1);
            check("result", outs[0], rows[i].exp);
            check("idle pc", o_pc, 11'h003);
            check("last order", o_order, 16'h5003);
            $display("row %0d done", i);
        end
        // divide leaves the quotient low; two shifts of 8 lift it up
        do_reset(2);
        ldr.put(11'h000, {clear_then_add, 11'h100});
        ldr.put(11'h001, {divide_op, 11'h101});
        ldr.put(11'h002, {shift_left_op, 11'h008});
        ldr.put(11'h003, {shift_left_op, 11'h008});
        ldr.put(11'h004, {test_out_op, 11'h000});
        ldr.put(11'h005, {subprogram_jump, 11'h005});
        ldr.put(11'h100, 16'h2000);
        ldr.put(11'h101, 16'h4000);
        ldr.stop();
        go(1);
        check("quotient", outs[0], 16'h4000);
        check("divide loop pc", o_pc, 11'h005);
        $display("divide test done");
        // sign jumps, digit transfer into a stored order, store
        do_reset(2);
        for (int j = 0; j < 13; j++) begin
            ldr.put(j[10:0], prog[j]);
        end
        ldr.put(11'h100, 16'hfffe);
        ldr.put(11'h101, 16'h0102);
        ldr.put(11'h102, 16'h5a5a);
        ldr.stop();
        go(2);
        check("modified order", outs[0], 16'h5a5a);
        check("stored word", outs[1], 16'h0102);
        check("loop pc", o_pc, 11'h00c);
        $display("jump test done");
        // reset in mid-run clears the sequencer
        @(posedge i_clk_sys);
        i_run <= 1'b1;
        repeat (20) @(posedge i_clk_sys);
        check("busy in run", o_busy, 1);
        do_reset(1);
        repeat (2) @(posedge i_clk_sys);
        check("idle after reset", o_busy, 0);
        check("pc after reset", o_pc, 0);
        $display("mid-run reset done");
        close_out();
    end
endmodule
